// ### design/udc_params.svh
// constants for the up/down counter and its controller
`ifndef UDC_PARAMS_SVH
`define UDC_PARAMS_SVH
`define UDC_CNT_W 4
`define UDC_CNT_MAX 4'hF
`define UDC_CNT_MIN 4'h0
`define UDC_CNT_RST 4'h0
`define UDC_CNT_ONE 4'h1
// controller register offsets
`define UDC_OFS_CTRL 8'h00
`define UDC_OFS_PRESET 8'h04
`define UDC_OFS_DIV 8'h08
`define UDC_OFS_STATUS 8'h0C
`define UDC_OFS_INTSTAT 8'h10
`define UDC_OFS_INTMASK 8'h14
// control bits
`define UDC_CTRL_RUN 0
`define UDC_CTRL_ENA 1
`define UDC_CTRL_DOWN 2
`define UDC_CTRL_PRESET 3
// status bits
`define UDC_ST_LIMIT 4
`define UDC_ST_CARRY_N 5
// interrupt bits
`define UDC_INT_W 2
`define UDC_INT_LIMIT 0
`define UDC_INT_CARRY 1
// clock divider: half period of the counter clock in sys_clk cycles
`define UDC_DIV_RST 8'h04
`define UDC_DIV_MIN 8'h03
`endif

// ### design/udc_pkg.sv
// types shared by the counter and its controller
package udc_pkg;
    typedef enum logic [3:0]
    {
        UDC_PRESET = 4'h1,
        UDC_HOLD = 4'h2,
        UDC_UP = 4'h4,
        UDC_DOWN = 4'h8
    } udc_mode_type;
    typedef enum logic [2:0]
    {
        UDC_CG_IDLE = 3'h1,
        UDC_CG_LOW = 3'h2,
        UDC_CG_HIGH = 3'h4
    } udc_cg_type;
endpackage

// ### design/udc_link_if.sv
// pins between the counter stage and the logic that drives it
`timescale 1ns/1ns
interface udc_link_if
(
    input wire logic sys_clk
);
    logic clockIn;
    logic countEnableN;
    logic countDown;
    logic presetStrobeN;
    logic [3:0] presetValue;
    logic [3:0] countValue;
    logic limitReached;
    logic rippleCarryN;
    modport dev
    (
        input clockIn, countEnableN, countDown, presetStrobeN, presetValue,
        output countValue, limitReached, rippleCarryN
    );
    modport host
    (
        output clockIn, countEnableN, countDown, presetStrobeN, presetValue,
        input countValue, limitReached, rippleCarryN
    );
endinterface

// ### design/udc_counter_dev.sv
// 4-bit up/down counter stage with preset, limit flag and ripple carry
// How it works
// - count wraps modulo sixteen both ways
// - preset strobe low loads preset value
// - preset overrides enable, direction and clock
// - enable high holds the count
// - enabled count steps on clock rise
// - direction low counts up, high down
// - limit flag at fifteen up, zero down
// - flag holds until count or direction changes
// - flag ignores the stage's own enable
// - carry low during clock low at limit
// - carry high when disabled or not limit
// - carry released soon after clock rises
// - limit flag never used as a clock
// - controls stable around the clock rise
// - ripple cascade clocks from lower carry
// - clock low outlasts the carry ripple
// - look-ahead enables combine lower limit flags
`timescale 1ns/1ns
`include "udc_params.svh"
module udc_counter_dev
    import udc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    udc_link_if.dev link,
    output logic [3:0] modeOut,
    output logic stepPulse,
    output logic wrapPulse
);

    // ==========================================================
    // helpers
    function automatic logic [3:0] stepCount
    (
        input logic [3:0] cur,
        input logic down
    );
        // 4-bit arithmetic wraps by itself
        if (down)
        begin
            stepCount = cur - `UDC_CNT_ONE;
        end
        else
        begin
            stepCount = cur + `UDC_CNT_ONE;
        end
    endfunction

    function automatic logic limitOf
    (
        input logic [3:0] cur,
        input logic down
    );
        // only count and direction enter here
        if (down)
        begin
            limitOf = (cur == `UDC_CNT_MIN);
        end
        else
        begin
            limitOf = (cur == `UDC_CNT_MAX);
        end
    endfunction

    // ==========================================================
    // state
    logic [3:0] count_q;
    logic [3:0] count_d;
    logic limit_q;
    logic limit_d;
    logic ripple_q;
    logic ripple_d;
    logic clkPrev_q;
    logic clkPrev_d;
    udc_mode_type mode_q;
    udc_mode_type mode_d;
    logic step_q;
    logic step_d;
    logic wrap_q;
    logic wrap_d;
    logic clkRise;

    // ==========================================================
    // next state
    always_comb
    begin
        clkPrev_d = link.clockIn;
        clkRise = link.clockIn & ~clkPrev_q;
        count_d = count_q;
        step_d = 1'b0;
        wrap_d = 1'b0;
        // preset first, then hold, then direction
        if (!link.presetStrobeN)
        begin
            mode_d = UDC_PRESET;
        end
        else if (link.countEnableN)
        begin
            mode_d = UDC_HOLD;
        end
        else if (link.countDown)
        begin
            mode_d = UDC_DOWN;
        end
        else
        begin
            mode_d = UDC_UP;
        end
        case (mode_d)
            UDC_PRESET:
            begin
                // level-sensitive: follows the value while the strobe is low
                count_d = link.presetValue;
            end
            UDC_HOLD:
            begin
                count_d = count_q;
            end
            UDC_UP,
            UDC_DOWN:
            begin
                if (clkRise)
                begin
                    count_d = stepCount(count_q, mode_d == UDC_DOWN);
                    step_d = 1'b1;
                    wrap_d = limitOf(count_q, mode_d == UDC_DOWN);
                end
            end
            default:
            begin
                count_d = count_q;
            end
        endcase
        // recomputed every cycle, so a direction flip moves it at once
        limit_d = limitOf(count_d, link.countDown);
        // low only in clock-low phase, enabled, at limit; rise clears it
        ripple_d = ~(~link.clockIn & ~link.countEnableN & limit_d);
    end

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            count_q <= `UDC_CNT_RST;
            limit_q <= 1'b0;
            ripple_q <= 1'b1;
            clkPrev_q <= 1'b0;
            mode_q <= UDC_HOLD;
            step_q <= 1'b0;
            wrap_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            limit_q <= limit_d;
            ripple_q <= ripple_d;
            clkPrev_q <= clkPrev_d;
            mode_q <= mode_d;
            step_q <= step_d;
            wrap_q <= wrap_d;
        end
    end

    // ==========================================================
    // outputs
    // outputs lag the pins by one sys_clk; a cascade must allow for it
    assign link.countValue = count_q;
    assign link.limitReached = limit_q;
    assign link.rippleCarryN = ripple_q;
    assign modeOut = mode_q;
    assign stepPulse = step_q;
    assign wrapPulse = wrap_q;

endmodule

// ### design/udc_ctrl_host.sv
// apb controller that clocks, steers and watches one counter stage
`timescale 1ns/1ns
`include "udc_params.svh"
module udc_ctrl_host
    import udc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    udc_link_if.host link
);

    // ==========================================================
    // state
    logic [3:0] ctrl_q, ctrl_d;
    logic [3:0] preset_q, preset_d;
    logic [7:0] div_q, div_d;
    logic [1:0] intStat_q, intStat_d;
    logic [1:0] intMask_q, intMask_d;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;
    logic irq_q, irq_d;
    udc_cg_type cg_q, cg_d;
    logic [7:0] half_q, half_d;
    logic clk_q, clk_d;
    logic enaN_q, enaN_d;
    logic down_q, down_d;
    logic presetN_q, presetN_d;
    logic limPrev_q, limPrev_d;
    logic carPrev_q, carPrev_d;
    logic setup, access;
    logic mapped;
    logic [31:0] rv;
    logic [7:0] halfLen;
    logic [1:0] events;

    // ==========================================================
    // next state
    always_comb
    begin
        setup = psel & ~penable;
        access = psel & penable & ready_q;
        mapped = 1'b1;
        rv = 32'h00000000;
        if (paddr == `UDC_OFS_CTRL)
        begin
            rv[3:0] = ctrl_q;
        end
        else if (paddr == `UDC_OFS_PRESET)
        begin
            rv[3:0] = preset_q;
        end
        else if (paddr == `UDC_OFS_DIV)
        begin
            rv[7:0] = div_q;
        end
        else if (paddr == `UDC_OFS_STATUS)
        begin
            rv[3:0] = link.countValue;
            rv[`UDC_ST_LIMIT] = link.limitReached;
            rv[`UDC_ST_CARRY_N] = link.rippleCarryN;
        end
        else if (paddr == `UDC_OFS_INTSTAT)
        begin
            rv[1:0] = intStat_q;
        end
        else if (paddr == `UDC_OFS_INTMASK)
        begin
            rv[1:0] = intMask_q;
        end
        else
        begin
            mapped = 1'b0;
        end
        ready_d = setup;
        rdata_d = setup ? rv : rdata_q;
        err_d = setup ? ~mapped : err_q;
        ctrl_d = ctrl_q;
        preset_d = preset_q;
        div_d = div_q;
        intMask_d = intMask_q;
        if (access && pwrite && mapped)
        begin
            if (paddr == `UDC_OFS_CTRL)
            begin
                ctrl_d = pwdata[3:0];
            end
            else if (paddr == `UDC_OFS_PRESET)
            begin
                preset_d = pwdata[3:0];
            end
            else if (paddr == `UDC_OFS_DIV)
            begin
                div_d = pwdata[7:0];
            end
            else if (paddr == `UDC_OFS_INTMASK)
            begin
                intMask_d = pwdata[1:0];
            end
        end
        // the flag is sampled for its edge here and read as a level in status, never used as a clock
        events[`UDC_INT_LIMIT] = link.limitReached & ~limPrev_q;
        events[`UDC_INT_CARRY] = ~link.rippleCarryN & carPrev_q;
        limPrev_d = link.limitReached;
        carPrev_d = link.rippleCarryN;
        intStat_d = intStat_q;
        // clear only what the read returned; a new event still wins
        if (access && !pwrite && paddr == `UDC_OFS_INTSTAT)
        begin
            intStat_d = intStat_q & ~rdata_q[1:0];
        end
        intStat_d = intStat_d | events;
        irq_d = |(intStat_d & intMask_d);
        // short half periods are stretched so the carry settles
        halfLen = (div_q < `UDC_DIV_MIN) ? `UDC_DIV_MIN : div_q;
        cg_d = cg_q;
        half_d = half_q;
        clk_d = clk_q;
        enaN_d = enaN_q;
        down_d = down_q;
        presetN_d = ~ctrl_q[`UDC_CTRL_PRESET];
        case (cg_q)
            UDC_CG_IDLE:
            begin
                clk_d = 1'b0;
                // clock stopped: controls may move freely
                enaN_d = ~ctrl_q[`UDC_CTRL_ENA];
                down_d = ctrl_q[`UDC_CTRL_DOWN];
                if (ctrl_q[`UDC_CTRL_RUN])
                begin
                    cg_d = UDC_CG_LOW;
                    half_d = halfLen;
                end
            end
            UDC_CG_LOW:
            begin
                half_d = half_q - 8'h01;
                if (half_q == 8'h01)
                begin
                    cg_d = UDC_CG_HIGH;
                    clk_d = 1'b1;
                    half_d = halfLen;
                end
            end
            UDC_CG_HIGH:
            begin
                half_d = half_q - 8'h01;
                if (half_q == 8'h01)
                begin
                    clk_d = 1'b0;
                    // change controls at the fall, far from the next rise
                    enaN_d = ~ctrl_q[`UDC_CTRL_ENA];
                    down_d = ctrl_q[`UDC_CTRL_DOWN];
                    half_d = halfLen;
                    cg_d = ctrl_q[`UDC_CTRL_RUN] ? UDC_CG_LOW : UDC_CG_IDLE;
                end
            end
            default:
            begin
                cg_d = UDC_CG_IDLE;
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ctrl_q <= 4'h0;
            preset_q <= 4'h0;
            div_q <= `UDC_DIV_RST;
            intStat_q <= 2'h0;
            intMask_q <= 2'h0;
            rdata_q <= 32'h00000000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
            irq_q <= 1'b0;
            cg_q <= UDC_CG_IDLE;
            half_q <= 8'h00;
            clk_q <= 1'b0;
            enaN_q <= 1'b1;
            down_q <= 1'b0;
            presetN_q <= 1'b1;
            limPrev_q <= 1'b0;
            carPrev_q <= 1'b1;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            preset_q <= preset_d;
            div_q <= div_d;
            intStat_q <= intStat_d;
            intMask_q <= intMask_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
            irq_q <= irq_d;
            cg_q <= cg_d;
            half_q <= half_d;
            clk_q <= clk_d;
            enaN_q <= enaN_d;
            down_q <= down_d;
            presetN_q <= presetN_d;
            limPrev_q <= limPrev_d;
            carPrev_q <= carPrev_d;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign irq = irq_q;
    assign link.clockIn = clk_q;
    assign link.countEnableN = enaN_q;
    assign link.countDown = down_q;
    assign link.presetStrobeN = presetN_q;
    assign link.presetValue = preset_q;

endmodule

// ### tb/udc_link_asserts.sv
// concurrent checks on the link between the controller and the counter stage
`timescale 1ns/1ns
module udc_link_asserts
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clockIn,
    input wire logic countEnableN,
    input wire logic countDown,
    input wire logic presetStrobeN,
    input wire logic [3:0] presetValue,
    input wire logic [3:0] countValue,
    input wire logic limitReached,
    input wire logic rippleCarryN
);
    // ====================
    // stepping and preset
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    property p_step_up;
        $rose(clockIn) && presetStrobeN && !countEnableN && !countDown |=> countValue == $past(countValue) + 4'h1;
    endproperty
    a_step_up: assert property (p_step_up) else $error("up step wrong");
    property p_step_down;
        $rose(clockIn) && presetStrobeN && !countEnableN && countDown |=> countValue == $past(countValue) - 4'h1;
    endproperty
    a_step_down: assert property (p_step_down) else $error("down step wrong");
    property p_hold;
        presetStrobeN && (countEnableN || !$rose(clockIn)) |=> $stable(countValue);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without a step");
    property p_preset;
        !presetStrobeN |=> countValue == $past(presetValue);
    endproperty
    a_preset: assert property (p_preset) else $error("preset not loaded");
    // ====================
    // limit flag and carry
    // direction seen one cycle late, as the flag is a flop
    property p_limit;
        1'b1 |=> limitReached == ($past(countDown) ? countValue == 4'h0 : countValue == 4'hF);
    endproperty
    a_limit: assert property (p_limit) else $error("limit flag wrong");
    property p_rc_cause;
        !rippleCarryN |-> $past(!clockIn && !countEnableN);
    endproperty
    a_rc_cause: assert property (p_rc_cause) else $error("carry low without cause");
    property p_rc_release;
        $rose(clockIn) |=> rippleCarryN;
    endproperty
    a_rc_release: assert property (p_rc_release) else $error("carry not released");
    property p_rc_low;
        (!clockIn && !countEnableN && limitReached && presetStrobeN && $stable(countDown)) [*2] |=> !rippleCarryN;
    endproperty
    a_rc_low: assert property (p_rc_low) else $error("carry not driven low");
    c_wrap: cover property (countValue == 4'hF ##1 countValue == 4'h0);
    c_carry: cover property ($fell(rippleCarryN));
    c_preset: cover property (!presetStrobeN);
endmodule

// ### tb/tb_top.sv
// self-checking bench: controller and counter stage joined by the link
`timescale 1ns/1ns
`include "udc_params.svh"
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pslverr, pready, irq, lastErr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int mismatches = 0;
    int cmp_count = 0;
    logic [3:0] modeOut;
    logic stepPulse, wrapPulse;
    always #20 sys_clk = ~sys_clk;
    udc_link_if link (.sys_clk(sys_clk));
    udc_counter_dev i_udc_counter_dev (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .modeOut(modeOut), .stepPulse(stepPulse), .wrapPulse(wrapPulse));
    udc_ctrl_host i_udc_ctrl_host (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link));
    udc_link_asserts i_udc_link_asserts (.sys_clk(sys_clk), .rst_n(rst_n), .clockIn(link.clockIn),
        .countEnableN(link.countEnableN), .countDown(link.countDown), .presetStrobeN(link.presetStrobeN),
        .presetValue(link.presetValue), .countValue(link.countValue), .limitReached(link.limitReached),
        .rippleCarryN(link.rippleCarryN));
    // ====================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // held until pready is seen high; no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // no timeout here: pready high ends this wait, and only the watchdog ends it if pready never comes
        while (pready !== 1'b1)
        begin
            @(posedge sys_clk);
        end
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic next_cnt(input logic [3:0] exp);
        logic [3:0] c;
        int n;
        c = link.countValue;
        n = 0;
        while (link.countValue === c && n < 200)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 200)
            mismatches++;
        chk({28'h0, link.countValue}, {28'h0, exp});
    endtask
    task automatic load(input logic [3:0] v);
        apb(1'b1, `UDC_OFS_PRESET, {28'h0, v});
        apb(1'b1, `UDC_OFS_CTRL, 32'h8);
        repeat (3) @(posedge sys_clk);
        chk({28'h0, link.countValue}, {28'h0, v});
        chk({28'h0, modeOut}, {28'h0, udc_pkg::UDC_PRESET});
    endtask
    // ====================
    // scenarios
    task automatic t_regs;
        apb(1'b0, `UDC_OFS_DIV, 32'h0);
        chk(rd, {24'h0, `UDC_DIV_RST});
        apb(1'b0, `UDC_OFS_INTMASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, lastErr}, 32'h1);
        chk(rd, 32'h0);
        $display("t_regs done");
    endtask
    task automatic t_preset;
        load(4'hE);
        load(4'hF);
        apb(1'b0, `UDC_OFS_STATUS, 32'h0);
        chk(rd, 32'h3F);
        apb(1'b0, `UDC_OFS_INTSTAT, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("t_preset done");
    endtask
    task automatic t_up_wrap;
        apb(1'b1, `UDC_OFS_INTMASK, 32'h3);
        apb(1'b1, `UDC_OFS_CTRL, 32'h3);
        next_cnt(4'h0);
        chk({31'h0, wrapPulse}, 32'h1);
        chk({31'h0, stepPulse}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `UDC_OFS_CTRL, 32'h0);
        apb(1'b0, `UDC_OFS_INTSTAT, 32'h0);
        chk(rd, 32'h2);
        chk({31'h0, irq}, 32'h0);
        $display("t_up_wrap done");
    endtask
    task automatic t_down;
        apb(1'b1, `UDC_OFS_INTMASK, 32'h0);
        load(4'h1);
        apb(1'b1, `UDC_OFS_CTRL, 32'h5);
        repeat (40) @(posedge sys_clk);
        chk({28'h0, link.countValue}, 32'h1);
        chk({28'h0, modeOut}, {28'h0, udc_pkg::UDC_HOLD});
        apb(1'b1, `UDC_OFS_CTRL, 32'h7);
        next_cnt(4'h0);
        chk({31'h0, link.limitReached}, 32'h1);
        next_cnt(4'hF);
        chk({31'h0, link.limitReached}, 32'h0);
        // a stop lets the running period finish, so wait until the clock parks low
        apb(1'b1, `UDC_OFS_CTRL, 32'h0);
        repeat (20) @(posedge sys_clk);
        apb(1'b1, `UDC_OFS_PRESET, 32'hF);
        apb(1'b1, `UDC_OFS_CTRL, 32'hC);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, link.limitReached}, 32'h0);
        apb(1'b1, `UDC_OFS_CTRL, 32'h2);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, link.limitReached}, 32'h1);
        chk({28'h0, link.countValue}, 32'hF);
        chk({31'h0, link.rippleCarryN}, 32'h0);
        $display("t_down done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #(40 * 5000);
        mismatches++;
        end_of_test();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_preset();
        t_up_wrap();
        t_down();
        end_of_test();
    end
endmodule
